// >>> rcwl_top.sv
// Purpose: Replacement class derivation and way-lock table for the
//          translation buffer.
// Assumes: All inputs come from logic on core_clk_in.
// Notes:   One result cycle after each request.
`timescale 1ns/1ps
`default_nettype none
`include "rcwl_map.svh"

module rcwl_top #(
  parameter int THR_W = 1
) (
  input  wire logic                     core_clk_in,
  input  wire logic                     srst_in,
  input  wire logic                     tlb_hw_managed_in,
  input  wire logic                     spr_wr_en_in,
  input  wire logic                     spr_rd_en_in,
  input  wire logic                     spr_priv_in,
  input  wire logic [`RCWL_SPR_W-1:0]   spr_num_in,
  input  wire logic [THR_W-1:0]         spr_thread_in,
  input  wire logic [`RCWL_REG_W-1:0]   spr_wdata_in,
  input  wire logic                     ifetch_valid_in,
  input  wire rcwl_pkg::rcwl_fetch_kind_e ifetch_kind_in,
  input  wire logic [THR_W-1:0]         ifetch_thread_in,
  input  wire logic [`RCWL_REG_W-1:0]   ifetch_ea_in,
  input  wire logic                     instr_relocate_bit_in,
  input  wire logic                     dacc_valid_in,
  input  wire logic                     dacc_cmo_in,
  input  wire logic [THR_W-1:0]         dacc_thread_in,
  input  wire logic [`RCWL_REG_W-1:0]   dacc_ea_in,
  input  wire logic                     data_relocate_bit_in,
  input  wire logic                     repl_req_in,
  input  wire logic [`RCWL_CLASS_W-1:0] repl_class_in,
  input  wire logic [`RCWL_WAYS-1:0]    repl_way_valid_in,
  input  wire logic [2:0]               repl_plru_in,
  output logic [`RCWL_REG_W-1:0]        spr_rdata_out,
  output logic                          spr_rd_valid_out,
  output logic                          spr_priv_fault_out,
  output logic                          ifetch_class_valid_out,
  output rcwl_pkg::rcwl_fetch_kind_e    ifetch_kind_out,
  output logic [`RCWL_CLASS_W-1:0]      ifetch_class_out,
  output logic [`RCWL_WAYS-1:0]         ifetch_way_mask_out,
  output logic                          dacc_class_valid_out,
  output logic                          dacc_cmo_out,
  output logic [`RCWL_CLASS_W-1:0]      dacc_class_out,
  output logic [`RCWL_WAYS-1:0]         dacc_way_mask_out,
  output logic                          repl_grant_out,
  output logic [1:0]                    repl_way_out,
  output logic                          repl_invalid_pick_out
);

  localparam int NTHR = 2 ** THR_W;
  localparam int NRNG = 2;

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  typedef logic [NTHR-1:0][NRNG-1:0][`RCWL_REG_W-1:0]   rcwl_regs_t;
  typedef logic [NTHR-1:0][NRNG-1:0][`RCWL_CLASS_W-1:0] rcwl_cls_t;

  typedef struct packed {
    rcwl_regs_t                   dstart;
    rcwl_regs_t                   dmask;
    rcwl_cls_t                    dclass;
    rcwl_regs_t                   istart;
    rcwl_regs_t                   imask;
    rcwl_cls_t                    iclass;
    logic [`RCWL_TABLE_W-1:0]     way_lock_table;
    logic [`RCWL_REG_W-1:0]       rdata;
    logic                         rd_valid;
    logic                         priv_fault;
    logic                         i_valid;
    rcwl_pkg::rcwl_fetch_kind_e   i_kind;
    logic [`RCWL_CLASS_W-1:0]     i_class;
    logic [`RCWL_WAYS-1:0]        i_ways;
    logic                         d_valid;
    logic                         d_cmo;
    logic [`RCWL_CLASS_W-1:0]     d_class;
    logic [`RCWL_WAYS-1:0]        d_ways;
    logic                         grant;
    logic [1:0]                   way;
    logic                         inv_pick;
    logic [`RCWL_WAYS-1:0]        elig;
  } rcwl_state_s;

  rcwl_state_s st_ff;
  rcwl_state_s nxt_st;

  // --------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------
  function automatic logic [`RCWL_WAYS-1:0] eff_entry(
    input logic [`RCWL_TABLE_W-1:0] tbl,
    input logic [`RCWL_CLASS_W-1:0] cls
  );
    logic [`RCWL_WAYS-1:0] e;
    e = tbl[(`RCWL_LAST_ENTRY - int'(cls)) * `RCWL_WAYS +: `RCWL_WAYS];
    if (e == `RCWL_NO_WAYS) begin
      e = `RCWL_ALL_WAYS;
    end
    return e;
  endfunction

  function automatic logic [`RCWL_WAYS-1:0] way_mask(
    input logic                     hw,
    input logic [`RCWL_TABLE_W-1:0] tbl,
    input logic [`RCWL_CLASS_W-1:0] cls
  );
    return hw ? eff_entry(tbl, cls) : `RCWL_ALL_WAYS;
  endfunction

  function automatic logic [1:0] first_way(input logic [3:0] m);
    logic [1:0] w;
    w = 2'h3;
    for (int i = 3; i >= 0; i--) begin
      if (m[i]) begin
        w = i[1:0];
      end
    end
    return w;
  endfunction

  function automatic logic [1:0] plru_pick(
    input logic [3:0] el,
    input logic [2:0] p
  );
    logic go_right;
    logic [1:0] w;
    go_right = p[0] ? (|el[3:2]) : !(|el[1:0]);
    if (go_right) begin
      w = (p[2] ? el[3] : !el[2]) ? 2'h3 : 2'h2;
    end else begin
      w = (p[1] ? el[1] : !el[0]) ? 2'h1 : 2'h0;
    end
    return w;
  endfunction

  // --------------------------------------------------------------------
  // Range compare
  // --------------------------------------------------------------------
  logic [NRNG-1:0]                    ihit;
  logic [NRNG-1:0]                    dhit;
  logic [NRNG-1:0][`RCWL_CLASS_W-1:0] icls;
  logic [NRNG-1:0][`RCWL_CLASS_W-1:0] dcls;

  for (genvar r = 0; r < NRNG; r++) begin : g_rng
    rcwl_range_match u_imatch (
      .start_in  (st_ff.istart[ifetch_thread_in][r]),
      .mask_in   (st_ff.imask[ifetch_thread_in][r]),
      .ea_in     (ifetch_ea_in),
      .reloc_in  (instr_relocate_bit_in),
      .class_in  (st_ff.iclass[ifetch_thread_in][r]),
      .hit_out   (ihit[r]),
      .class_out (icls[r])
    );
    rcwl_range_match u_dmatch (
      .start_in  (st_ff.dstart[dacc_thread_in][r]),
      .mask_in   (st_ff.dmask[dacc_thread_in][r]),
      .ea_in     (dacc_ea_in),
      .reloc_in  (data_relocate_bit_in),
      .class_in  (st_ff.dclass[dacc_thread_in][r]),
      .hit_out   (dhit[r]),
      .class_out (dcls[r])
    );
  end

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  logic                     spr_ok;
  logic [`RCWL_CLASS_W-1:0] i_id;
  logic [`RCWL_CLASS_W-1:0] d_id;
  logic [`RCWL_WAYS-1:0]    r_elig;
  logic [`RCWL_WAYS-1:0]    r_inv;

  always_comb begin
    nxt_st = st_ff;
    spr_ok = spr_priv_in;
    i_id   = icls[0] | icls[1];
    d_id   = dcls[0] | dcls[1];
    r_elig = way_mask(tlb_hw_managed_in, st_ff.way_lock_table,
                      repl_class_in);
    r_inv  = r_elig & ~repl_way_valid_in;

    nxt_st.priv_fault = (spr_wr_en_in || spr_rd_en_in) && !spr_ok;
    if (spr_wr_en_in && spr_ok) begin
      case (spr_num_in)
        `RCWL_SPR_TABLE:
          nxt_st.way_lock_table = spr_wdata_in[`RCWL_TABLE_W-1:0];
        `RCWL_SPR_DSTART0: nxt_st.dstart[spr_thread_in][0] = spr_wdata_in;
        `RCWL_SPR_DSTART1: nxt_st.dstart[spr_thread_in][1] = spr_wdata_in;
        `RCWL_SPR_DMASK0:  nxt_st.dmask[spr_thread_in][0]  = spr_wdata_in;
        `RCWL_SPR_DMASK1:  nxt_st.dmask[spr_thread_in][1]  = spr_wdata_in;
        `RCWL_SPR_DCLASS0:
          nxt_st.dclass[spr_thread_in][0] = spr_wdata_in[`RCWL_CLASS_W-1:0];
        `RCWL_SPR_DCLASS1:
          nxt_st.dclass[spr_thread_in][1] = spr_wdata_in[`RCWL_CLASS_W-1:0];
        `RCWL_SPR_ISTART0: nxt_st.istart[spr_thread_in][0] = spr_wdata_in;
        `RCWL_SPR_ISTART1: nxt_st.istart[spr_thread_in][1] = spr_wdata_in;
        `RCWL_SPR_IMASK0:  nxt_st.imask[spr_thread_in][0]  = spr_wdata_in;
        `RCWL_SPR_IMASK1:  nxt_st.imask[spr_thread_in][1]  = spr_wdata_in;
        `RCWL_SPR_ICLASS0:
          nxt_st.iclass[spr_thread_in][0] = spr_wdata_in[`RCWL_CLASS_W-1:0];
        `RCWL_SPR_ICLASS1:
          nxt_st.iclass[spr_thread_in][1] = spr_wdata_in[`RCWL_CLASS_W-1:0];
        default: begin
        end
      endcase
    end

    nxt_st.rd_valid = spr_rd_en_in && spr_ok;
    nxt_st.rdata    = `RCWL_RST_REG;
    if (spr_rd_en_in && spr_ok) begin
      case (spr_num_in)
        `RCWL_SPR_TABLE:
          nxt_st.rdata[`RCWL_TABLE_W-1:0] = st_ff.way_lock_table;
        `RCWL_SPR_DSTART0: nxt_st.rdata = st_ff.dstart[spr_thread_in][0];
        `RCWL_SPR_DSTART1: nxt_st.rdata = st_ff.dstart[spr_thread_in][1];
        `RCWL_SPR_DMASK0:  nxt_st.rdata = st_ff.dmask[spr_thread_in][0];
        `RCWL_SPR_DMASK1:  nxt_st.rdata = st_ff.dmask[spr_thread_in][1];
        `RCWL_SPR_DCLASS0:
          nxt_st.rdata[`RCWL_CLASS_W-1:0] = st_ff.dclass[spr_thread_in][0];
        `RCWL_SPR_DCLASS1:
          nxt_st.rdata[`RCWL_CLASS_W-1:0] = st_ff.dclass[spr_thread_in][1];
        `RCWL_SPR_ISTART0: nxt_st.rdata = st_ff.istart[spr_thread_in][0];
        `RCWL_SPR_ISTART1: nxt_st.rdata = st_ff.istart[spr_thread_in][1];
        `RCWL_SPR_IMASK0:  nxt_st.rdata = st_ff.imask[spr_thread_in][0];
        `RCWL_SPR_IMASK1:  nxt_st.rdata = st_ff.imask[spr_thread_in][1];
        `RCWL_SPR_ICLASS0:
          nxt_st.rdata[`RCWL_CLASS_W-1:0] = st_ff.iclass[spr_thread_in][0];
        `RCWL_SPR_ICLASS1:
          nxt_st.rdata[`RCWL_CLASS_W-1:0] = st_ff.iclass[spr_thread_in][1];
        default: begin
        end
      endcase
    end

    // Fetch side, any fetch kind
    nxt_st.i_valid = ifetch_valid_in;
    nxt_st.i_kind  = ifetch_kind_in;
    nxt_st.i_class = ifetch_valid_in ? i_id : `RCWL_CLASS_ZERO;
    nxt_st.i_ways  = ifetch_valid_in
                     ? way_mask(tlb_hw_managed_in, st_ff.way_lock_table, i_id)
                     : `RCWL_ALL_WAYS;

    // Data side, cache management ops included
    nxt_st.d_valid = dacc_valid_in;
    nxt_st.d_cmo   = dacc_valid_in && dacc_cmo_in;
    nxt_st.d_class = dacc_valid_in ? d_id : `RCWL_CLASS_ZERO;
    nxt_st.d_ways  = dacc_valid_in
                     ? way_mask(tlb_hw_managed_in, st_ff.way_lock_table, d_id)
                     : `RCWL_ALL_WAYS;

    // Victim choice on a miss
    nxt_st.grant    = repl_req_in && tlb_hw_managed_in;
    nxt_st.elig     = r_elig;
    nxt_st.inv_pick = nxt_st.grant && (r_inv != `RCWL_NO_WAYS);
    nxt_st.way      = 2'h0;
    if (nxt_st.grant) begin
      nxt_st.way = (r_inv != `RCWL_NO_WAYS) ? first_way(r_inv)
                                            : plru_pick(r_elig,
                                                        repl_plru_in);
    end
  end

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      st_ff                <= '0;
      st_ff.way_lock_table <= `RCWL_RST_TABLE;
      st_ff.i_kind         <= rcwl_pkg::RCWL_FETCH_SEQ;
      st_ff.i_ways         <= `RCWL_ALL_WAYS;
      st_ff.d_ways         <= `RCWL_ALL_WAYS;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign spr_rdata_out          = st_ff.rdata;
  assign spr_rd_valid_out       = st_ff.rd_valid;
  assign spr_priv_fault_out     = st_ff.priv_fault;
  assign ifetch_class_valid_out = st_ff.i_valid;
  assign ifetch_kind_out        = st_ff.i_kind;
  assign ifetch_class_out       = st_ff.i_class;
  assign ifetch_way_mask_out    = st_ff.i_ways;
  assign dacc_class_valid_out   = st_ff.d_valid;
  assign dacc_cmo_out           = st_ff.d_cmo;
  assign dacc_class_out         = st_ff.d_class;
  assign dacc_way_mask_out      = st_ff.d_ways;
  assign repl_grant_out         = st_ff.grant;
  assign repl_way_out           = st_ff.way;
  assign repl_invalid_pick_out  = st_ff.inv_pick;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (srst_in);

  a_fetch_class_out: assert property (
    ifetch_valid_in |=> ifetch_class_valid_out
      && ifetch_kind_out == $past(ifetch_kind_in))
    else $error("fetch class not produced");

  a_fetch_nohit_zero: assert property (
    ifetch_valid_in && !(|ihit) |=> ifetch_class_out == `RCWL_CLASS_ZERO)
    else $error("fetch without hit has nonzero class");

  a_data_nohit_zero: assert property (
    dacc_valid_in && !(|dhit) |=> dacc_class_out == `RCWL_CLASS_ZERO)
    else $error("data without hit has nonzero class");

  a_single_hit_class: assert property (
    dacc_valid_in && dhit[1] && !dhit[0]
      |=> dacc_class_out == $past(dcls[1]))
    else $error("data class not taken from hit range");

  a_sw_mode_free: assert property (
    dacc_valid_in && !tlb_hw_managed_in |=> dacc_way_mask_out == 4'hF)
    else $error("way mask applied in software mode");

  a_sw_no_grant: assert property (
    repl_req_in && !tlb_hw_managed_in |=> !repl_grant_out)
    else $error("victim chosen in software mode");

  a_grant_eligible: assert property (
    repl_grant_out |-> st_ff.elig[repl_way_out] && st_ff.elig != 4'h0)
    else $error("locked way chosen");

  a_invalid_first: assert property (
    repl_req_in && tlb_hw_managed_in && |(r_elig & ~repl_way_valid_in)
      |=> repl_grant_out && repl_invalid_pick_out
          && ((4'h1 << repl_way_out) & $past(repl_way_valid_in)) == 4'h0)
    else $error("valid way taken while invalid eligible");

  a_priv_gate: assert property (
    spr_wr_en_in && !spr_priv_in
      |=> spr_priv_fault_out && $stable(st_ff.way_lock_table))
    else $error("unprivileged write took effect");

  a_table_upper_zero: assert property (
    spr_rd_en_in && spr_priv_in && spr_num_in == `RCWL_SPR_TABLE
      |=> spr_rd_valid_out && spr_rdata_out[`RCWL_REG_W-1:`RCWL_TABLE_W] == '0)
    else $error("table upper half not zero");

endmodule
`default_nettype wire

// >>> rcwl_map.svh
// Purpose: Named offsets, field positions and reset values of the
//          replacement class and way-lock block.
// Assumes: Registers are reached by privileged special-register moves.
// Notes:   Definitions only.
`ifndef RCWL_MAP_SVH
`define RCWL_MAP_SVH

// ----------------------------------------------------------------------
// Special-register numbers
// ----------------------------------------------------------------------
`define RCWL_SPR_W          10
`define RCWL_SPR_TABLE      10'h3F4
`define RCWL_SPR_DSTART0    10'h3E0
`define RCWL_SPR_DSTART1    10'h3E1
`define RCWL_SPR_DMASK0     10'h3E2
`define RCWL_SPR_DMASK1     10'h3E3
`define RCWL_SPR_DCLASS0    10'h3E4
`define RCWL_SPR_DCLASS1    10'h3E5
`define RCWL_SPR_ISTART0    10'h3E8
`define RCWL_SPR_ISTART1    10'h3E9
`define RCWL_SPR_IMASK0     10'h3EA
`define RCWL_SPR_IMASK1     10'h3EB
`define RCWL_SPR_ICLASS0    10'h3EC
`define RCWL_SPR_ICLASS1    10'h3ED

// ----------------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------------
`define RCWL_REG_W          64
`define RCWL_VALID_BIT      0
`define RCWL_RELOC_BIT      1
`define RCWL_CMP_LO         12
`define RCWL_MASK_HI        31
`define RCWL_EA_HI_LO       32
`define RCWL_CLASS_W        3
`define RCWL_WAYS           4
`define RCWL_TABLE_W        32
`define RCWL_LAST_ENTRY     7
`define RCWL_ALL_WAYS       4'hF
`define RCWL_NO_WAYS        4'h0
`define RCWL_CLASS_ZERO     3'h0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RCWL_RST_REG        64'h0000_0000_0000_0000
`define RCWL_RST_CLASS      3'h0
`define RCWL_RST_TABLE      32'h0000_0000

`endif

// >>> rcwl_pkg.sv
// Purpose: Types shared by the replacement class and way-lock block.
// Assumes: Nothing beyond the map header.
// Notes:   Fetch kinds are one-hot so a pipeline can tag them cheaply.
`default_nettype none
package rcwl_pkg;

  typedef enum logic [4:0] {
    RCWL_FETCH_SEQ      = 5'h01,
    RCWL_FETCH_BR_SPEC  = 5'h02,
    RCWL_FETCH_BR_TAKEN = 5'h04,
    RCWL_FETCH_PREFETCH = 5'h08,
    RCWL_FETCH_VECTOR   = 5'h10
  } rcwl_fetch_kind_e;

endpackage
`default_nettype wire

// >>> rcwl_range_match.sv
// Purpose: One address range compare and gated class value.
// Assumes: Start and mask use bit 0 as least significant.
// Notes:   Purely combinational.
`timescale 1ns/1ps
`default_nettype none
`include "rcwl_map.svh"

module rcwl_range_match (
  input  wire logic [`RCWL_REG_W-1:0]   start_in,
  input  wire logic [`RCWL_REG_W-1:0]   mask_in,
  input  wire logic [`RCWL_REG_W-1:0]   ea_in,
  input  wire logic                     reloc_in,
  input  wire logic [`RCWL_CLASS_W-1:0] class_in,
  output logic                          hit_out,
  output logic [`RCWL_CLASS_W-1:0]      class_out
);

  logic [`RCWL_REG_W-1:`RCWL_CMP_LO] cmp_addr;

  always_comb begin
    cmp_addr = {ea_in[`RCWL_REG_W-1:`RCWL_EA_HI_LO],
                ea_in[`RCWL_MASK_HI:`RCWL_CMP_LO]
                & mask_in[`RCWL_MASK_HI:`RCWL_CMP_LO]};
    hit_out = start_in[`RCWL_VALID_BIT]
              && (start_in[`RCWL_RELOC_BIT] == reloc_in)
              && (start_in[`RCWL_REG_W-1:`RCWL_CMP_LO] == cmp_addr);
    class_out = class_in & {`RCWL_CLASS_W{hit_out}};
  end

endmodule
`default_nettype wire

// >>> rcwl_tlb_set_model.sv
// Purpose: Far-side model of one translation-buffer set for the block.
// Assumes: A grant fills the chosen way and ages the pLRU tree.
// Notes:   flush_in empties the set so invalid-first picks recur.
`timescale 1ns/1ps
`default_nettype none

module rcwl_tlb_set_model (
  input  wire logic       clk_in,
  input  wire logic       srst_in,
  input  wire logic       flush_in,
  input  wire logic       grant_in,
  input  wire logic [1:0] way_in,
  output var  logic [3:0] way_valid_out,
  output var  logic [2:0] plru_out
);
  always_ff @(posedge clk_in) begin
    if (srst_in || flush_in) begin
      way_valid_out <= 4'h0;
      if (srst_in) plru_out <= 3'h0;
    end else if (grant_in) begin
      way_valid_out[way_in] <= 1'h1;
      plru_out[0] <= ~way_in[1];
      if (way_in[1]) plru_out[2] <= ~way_in[0];
      else plru_out[1] <= ~way_in[0];
    end
  end
endmodule

`default_nettype wire

// >>> rcwl_testbench.sv
// Purpose: Self-checking bench for the class and way-lock block.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes:   Random ranges per thread; expectations from bench functions.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic        clk = 1'h0, srst = 1'h1, hw = 1'h1, wr = 1'h0, rd = 1'h0;
  logic        priv = 1'h1, ivld = 1'h0, dvld = 1'h0, cmo = 1'h0;
  logic        irel = 1'h0, drel = 1'h0, rq = 1'h0, flush = 1'h0;
  logic [0:0]  thr = 1'h0, ithr = 1'h0, dthr = 1'h0;
  logic [9:0]  num = 10'h000;
  logic [63:0] wd = 64'h0, iaddr = 64'h0, daddr = 64'h0, rdata;
  logic [2:0]  rcls = 3'h0, plru, icls, dcls;
  logic [3:0]  vv, imask, dmask;
  logic [1:0]  way;
  logic        rvld, flt, icv, dcv, cmoo, gnt, inv;
  rcwl_pkg::rcwl_fetch_kind_e kin = rcwl_pkg::RCWL_FETCH_SEQ, kout;
  logic [63:0] st [2][2][2];
  logic [63:0] mk [2][2][2];
  logic [2:0]  cl [2][2][2];
  logic [31:0] tbl;
  int          n_errors = 0, n_tests = 0, cyc = 0;
  integer      seed = 32'h6047;

  rcwl_top #(.THR_W(1)) uut (
    .core_clk_in(clk), .srst_in(srst), .tlb_hw_managed_in(hw),
    .spr_wr_en_in(wr), .spr_rd_en_in(rd), .spr_priv_in(priv),
    .spr_num_in(num), .spr_thread_in(thr), .spr_wdata_in(wd),
    .ifetch_valid_in(ivld), .ifetch_kind_in(kin), .ifetch_thread_in(ithr),
    .ifetch_ea_in(iaddr), .instr_relocate_bit_in(irel),
    .dacc_valid_in(dvld), .dacc_cmo_in(cmo), .dacc_thread_in(dthr),
    .dacc_ea_in(daddr), .data_relocate_bit_in(drel),
    .repl_req_in(rq), .repl_class_in(rcls), .repl_way_valid_in(vv),
    .repl_plru_in(plru), .spr_rdata_out(rdata), .spr_rd_valid_out(rvld),
    .spr_priv_fault_out(flt), .ifetch_class_valid_out(icv),
    .ifetch_kind_out(kout), .ifetch_class_out(icls),
    .ifetch_way_mask_out(imask), .dacc_class_valid_out(dcv),
    .dacc_cmo_out(cmoo), .dacc_class_out(dcls), .dacc_way_mask_out(dmask),
    .repl_grant_out(gnt), .repl_way_out(way), .repl_invalid_pick_out(inv)
  );

  rcwl_tlb_set_model far_set (
    .clk_in(clk), .srst_in(srst), .flush_in(flush), .grant_in(gnt),
    .way_in(way), .way_valid_out(vv), .plru_out(plru)
  );

  always #12.5 clk = ~clk;

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic wrap_up;
    if (n_errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] e, g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic [3:0] elig(input logic [2:0] c);
    logic [3:0] e;
    e = tbl[31-4*c -: 4];
    return (e == 4'h0) ? 4'hF : e;
  endfunction

  function automatic logic [2:0] exp_cls(input int s, input logic t,
                                         input logic [63:0] a,
                                         input logic rel);
    logic [2:0] c;
    c = 3'h0;
    for (int n = 0; n < 2; n++) begin
      if (st[t][s][n][0] && st[t][s][n][1] == rel && st[t][s][n][63:12]
          == {a[63:32], a[31:12] & mk[t][s][n][31:12]}) c |= cl[t][s][n];
    end
    return c;
  endfunction

  function automatic logic [2:0] exp_pick(input logic [2:0] c,
                                          input logic [3:0] v,
                                          input logic [2:0] p);
    logic [3:0] e;
    logic       s, f;
    logic [1:0] w;
    e = elig(c);
    f = 1'h0;
    for (int i = 3; i >= 0; i--) begin
      if (e[i] && !v[i]) begin
        f = 1'h1;
        w = 2'(i);
      end
    end
    if (f) return {1'h1, w};
    s = p[0];
    if (e[{s, 1'h0} +: 2] == 2'h0) s = ~s;
    w = {s, s ? p[2] : p[1]};
    if (!e[w]) w[0] = ~w[0];
    return {1'h0, w};
  endfunction

  function automatic logic [63:0] pick_addr(input int s, input logic t);
    logic [63:0] r, b, m;
    r = {$random(seed), $random(seed)};
    b = st[t][s][r[0]];
    m = mk[t][s][r[0]];
    if (r[63:62] == 2'h0) return r;
    return {b[63:32], (b[31:12] & m[31:12]) | (r[31:12] & ~m[31:12]),
            r[11:0]};
  endfunction

  task automatic spr(input logic w, input logic [9:0] n, input logic t,
                     input logic [63:0] d, input logic p, input logic [63:0] e);
    wr = w;
    rd = !w;
    num = n;
    thr = t;
    wd = d;
    priv = p;
    @(posedge clk);
    #1;
    chk("fault", {63'h0, !p}, {63'h0, flt});
    chk("rd_valid", {63'h0, !w && p}, {63'h0, rvld});
    if (!w && p) chk("rdata", e, rdata);
  endtask

  task automatic setup;
    logic [63:0] b;
    logic [9:0]  a;
    for (int t = 0; t < 2; t++) for (int s = 0; s < 2; s++)
      for (int n = 0; n < 2; n++) begin
        b = {$random(seed), $random(seed)};
        mk[t][s][n] = {$random(seed), 32'hFFFF_FFFF << (12 + b[40:36] % 21)};
        st[t][s][n] = b & {32'hFFFF_FFFF, mk[t][s][n][31:12], 12'hFFF};
        if (n == 1) st[t][s][1][63] = ~st[t][s][0][63];
        st[t][s][n][0] = b[0] | b[1];
        cl[t][s][n] = 3'($random(seed));
        a = (s == 1) ? 10'h3E8 : 10'h3E0;
        spr(1, a + 10'(n), t, st[t][s][n], 1, 0);
        spr(1, a + 10'(n + 2), t, mk[t][s][n], 1, 0);
        spr(1, a + 10'(n + 4), t, {61'h0, cl[t][s][n]}, 1, 0);
        spr(0, a + 10'(n), t, 0, 1, st[t][s][n]);
        spr(0, a + 10'(n + 2), t, 0, 1, mk[t][s][n]);
        spr(0, a + 10'(n + 4), t, 0, 1, {61'h0, cl[t][s][n]});
      end
  endtask

  task automatic traffic;
    logic [2:0] c;
    logic [3:0] m;
    repeat (400) begin
      {ivld, dvld, ithr, dthr, irel, drel, cmo, hw} = 8'($random(seed));
      kin = rcwl_pkg::rcwl_fetch_kind_e'(5'h01
            << ($unsigned($random(seed)) % 5));
      iaddr = pick_addr(1, ithr);
      daddr = pick_addr(0, dthr);
      @(posedge clk);
      #1;
      chk("i_valid", {63'h0, ivld}, {63'h0, icv});
      chk("d_valid", {63'h0, dvld}, {63'h0, dcv});
      c = ivld ? exp_cls(1, ithr, iaddr, irel) : 3'h0;
      m = (hw && ivld) ? elig(c) : 4'hF;
      if (ivld) chk("i_kind", {59'h0, kin}, {59'h0, kout});
      chk("i_class", {61'h0, c}, {61'h0, icls});
      chk("i_mask", {60'h0, m}, {60'h0, imask});
      c = dvld ? exp_cls(0, dthr, daddr, drel) : 3'h0;
      m = (hw && dvld) ? elig(c) : 4'hF;
      if (dvld) chk("d_cmo", {63'h0, cmo}, {63'h0, cmoo});
      chk("d_class", {61'h0, c}, {61'h0, dcls});
      chk("d_mask", {60'h0, m}, {60'h0, dmask});
    end
  endtask

  task automatic repl(input logic [2:0] c, input logic h);
    logic [2:0] e;
    rq = 1'h1;
    rcls = c;
    hw = h;
    e = exp_pick(c, vv, plru);
    @(posedge clk);
    #1;
    rq = 1'h0;
    chk("grant", {63'h0, h}, {63'h0, gnt});
    if (h) chk("victim", {61'h0, e}, {61'h0, inv, way});
    @(posedge clk);
    #1;
  endtask

  initial begin
    repeat (20) @(posedge clk);
    #1;
    srst = 1'h0;
    tbl = $random(seed) & $random(seed);
    tbl[23:20] = 4'h0;
    tbl[11:8] = 4'h9;
    tbl[31:28] = 4'h6;
    spr(1, 10'h3F4, 0, {$random(seed), tbl}, 1, 0);
    spr(0, 10'h3F4, 0, 0, 1, {32'h0, tbl});
    spr(1, 10'h3F4, 0, 64'h0, 0, 0);
    spr(0, 10'h3F4, 1, 0, 1, {32'h0, tbl});
    spr(0, 10'h000, 0, 0, 1, 64'h0);
    setup();
    wr = 1'h0;
    rd = 1'h0;
    traffic();
    repeat (6) repl(3'h5, 1'h1);
    repeat (200) begin
      if ($random(seed) % 8 == 0) begin
        flush = 1'h1;
        @(posedge clk);
        #1;
        flush = 1'h0;
      end
      repl(3'($random(seed)), $random(seed) % 4 != 0);
    end
    wrap_up();
  end
endmodule

`default_nettype wire
